/* File: pkg/pin_select_consts.svh */
// Purpose: offsets, field positions and reset values of the remappable pin select unit
// Assumes: registers sit on aligned 32-bit words of an Avalon-MM slave, 16 bits used
// Notes: What this block does list follows
// What this block does
// - eight-bit input select; value N routes remappable pin N, pins 1 to 181
// - input select of zero feeds the peripheral input a constant low
// - unimplemented bits of every select register read back as zero
// - implemented select bits are read/write and clear to zero at reset
// - sync one in bits 15-8 of its register; sync two in bits 7-0 of another
// - six-bit output function per pin; even pin bits 5-0, odd pin bits 13-8
`ifndef PIN_SELECT_CONSTS_SVH
`define PIN_SELECT_CONSTS_SVH
`define OFS_UART_SEL 8'h00
`define OFS_SPI_CD_SEL 8'h04
`define OFS_SPI_SS_SEL 8'h08
`define OFS_SYNC1_SEL 8'h0C
`define OFS_SYNC2_SEL 8'h10
`define OFS_FLT56_SEL 8'h14
`define OFS_FLT78_SEL 8'h18
`define OFS_OUT3233_SEL 8'h1C
`define OFS_OUT3435_SEL 8'h20
`define MASK_BOTH_BYTES 16'hFFFF
`define MASK_LOW_BYTE 16'h00FF
`define MASK_HIGH_BYTE 16'hFF00
`define MASK_OUT_PAIR 16'h3F3F
`define SEL_RESET 16'h0000
`define LOW_LSB 0
`define HIGH_LSB 8
`define UNMAPPED_READ 32'h0000_0000
`endif

/* File: pkg/pin_select_pkg.sv */
// Purpose: types shared by the remappable pin select unit
// Assumes: nothing beyond the constants header
// Notes: field widths are fixed here; the pin count is the NUM_PINS parameter of each module
package pin_select_pkg;
    typedef logic [7:0] pin_choice_type;
    typedef logic [5:0] out_func_type;
    typedef struct packed {
        logic uart_receive_input;
        logic uart_clear_to_send_input;
        logic spi_clock_in;
        logic spi_data_in;
        logic spi_slave_select_input;
        logic pwm_sync_one_in;
        logic pwm_sync_two_in;
        logic fault_five_in;
        logic fault_six_in;
        logic fault_seven_in;
        logic fault_eight_in;
    } periph_in_type;
    typedef struct packed {
        out_func_type pin35_output_function;
        out_func_type pin34_output_function;
        out_func_type pin33_output_function;
        out_func_type pin32_output_function;
    } out_sel_type;
endpackage

/* File: design/pin_input_route.sv */
// Purpose: routes one remappable pin, or a constant low, to one peripheral input
// Assumes: pins vector is already synchronised; index 0 unused
// Notes: choices above the pin count also give low
module pin_input_route
    import pin_select_pkg::*;
#(
    parameter int NUM_PINS = 181
)
(
    input wire logic [NUM_PINS:0] pins,
    input wire pin_choice_type choice,
    output logic routed
);
    always_comb
    begin
        if (choice == 8'h00)
        begin
            routed = 1'b0;
        end
        else if (int'(choice) <= NUM_PINS)
        begin
            routed = pins[choice];
        end
        else
        begin
            routed = 1'b0;
        end
    end
endmodule

/* File: design/remappable_pin_select.sv */
// Purpose: remappable pin select unit with Avalon-MM register access
// Assumes: 100 MHz clk, asynchronous active-low reset, pins come from outside the clock domain
// Notes: answers an access from idle in one cycle of waitrequest high, then low; one started right after the last takes two
`include "pin_select_consts.svh"
module remappable_pin_select
    import pin_select_pkg::*;
#(
    parameter int NUM_PINS = 181
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [NUM_PINS:1] remappable_pin,
    output periph_in_type periph_in,
    output out_sel_type out_sel
);
    typedef enum logic [1:0] {IDLE, ANSWER, DONE} bus_state_type;

    bus_state_type state_q, state_d;
    logic [15:0] uart_q, uart_d;
    logic [15:0] spi_cd_q, spi_cd_d;
    logic [15:0] spi_ss_q, spi_ss_d;
    logic [15:0] sync1_q, sync1_d;
    logic [15:0] sync2_q, sync2_d;
    logic [15:0] flt56_q, flt56_d;
    logic [15:0] flt78_q, flt78_d;
    logic [15:0] out3233_q, out3233_d;
    logic [15:0] out3435_q, out3435_d;
    logic [31:0] rdata_q, rdata_d;
    logic [NUM_PINS:1] pin_meta_q;
    logic [NUM_PINS:1] pin_sync_q;
    logic [NUM_PINS:0] pins_vec;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic [15:0] rsel;
    logic hit;
    logic do_write;

    // two-stage synchroniser on every pin before any routing reads it
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end
        else
        begin
            pin_meta_q <= remappable_pin;
            pin_sync_q <= pin_meta_q;
        end
    end

    assign pins_vec = {pin_sync_q, 1'b0};
    assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wdata = avs_writedata[15:0];
    // the write lands only on the edge where waitrequest is seen low
    assign do_write = avs_write && (state_q == ANSWER);

    function automatic logic [15:0] upd(input logic [15:0] cur, input logic [15:0] impl);
        upd = ((cur & ~wmask) | (wdata & wmask)) & impl;
    endfunction

    // bus handshake: one wait cycle so read data comes from a flop
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    state_d = ANSWER;
                end
            end
            ANSWER:
            begin
                state_d = DONE;
            end
            DONE:
            begin
                state_d = IDLE;
            end
        endcase
    end

    always_comb
    begin
        hit = 1'b1;
        rsel = 16'h0000;
        unique case (avs_address)
            `OFS_UART_SEL: rsel = uart_q;
            `OFS_SPI_CD_SEL: rsel = spi_cd_q;
            `OFS_SPI_SS_SEL: rsel = spi_ss_q;
            `OFS_SYNC1_SEL: rsel = sync1_q;
            `OFS_SYNC2_SEL: rsel = sync2_q;
            `OFS_FLT56_SEL: rsel = flt56_q;
            `OFS_FLT78_SEL: rsel = flt78_q;
            `OFS_OUT3233_SEL: rsel = out3233_q;
            `OFS_OUT3435_SEL: rsel = out3435_q;
            default: hit = 1'b0;
        endcase
    end

    always_comb
    begin
        uart_d = uart_q;
        spi_cd_d = spi_cd_q;
        spi_ss_d = spi_ss_q;
        sync1_d = sync1_q;
        sync2_d = sync2_q;
        flt56_d = flt56_q;
        flt78_d = flt78_q;
        out3233_d = out3233_q;
        out3435_d = out3435_q;
        rdata_d = rdata_q;
        if (state_q == IDLE && avs_read)
        begin
            // unimplemented bits are never stored, so they read as zero
            rdata_d = hit ? {16'h0000, rsel} : `UNMAPPED_READ;
        end
        if (do_write)
        begin
            unique case (avs_address)
                `OFS_UART_SEL: uart_d = upd(uart_q, `MASK_BOTH_BYTES);
                `OFS_SPI_CD_SEL: spi_cd_d = upd(spi_cd_q, `MASK_BOTH_BYTES);
                `OFS_SPI_SS_SEL: spi_ss_d = upd(spi_ss_q, `MASK_LOW_BYTE);
                `OFS_SYNC1_SEL: sync1_d = upd(sync1_q, `MASK_HIGH_BYTE);
                `OFS_SYNC2_SEL: sync2_d = upd(sync2_q, `MASK_LOW_BYTE);
                `OFS_FLT56_SEL: flt56_d = upd(flt56_q, `MASK_BOTH_BYTES);
                `OFS_FLT78_SEL: flt78_d = upd(flt78_q, `MASK_BOTH_BYTES);
                `OFS_OUT3233_SEL: out3233_d = upd(out3233_q, `MASK_OUT_PAIR);
                `OFS_OUT3435_SEL: out3435_d = upd(out3435_q, `MASK_OUT_PAIR);
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= IDLE;
            uart_q <= `SEL_RESET;
            spi_cd_q <= `SEL_RESET;
            spi_ss_q <= `SEL_RESET;
            sync1_q <= `SEL_RESET;
            sync2_q <= `SEL_RESET;
            flt56_q <= `SEL_RESET;
            flt78_q <= `SEL_RESET;
            out3233_q <= `SEL_RESET;
            out3435_q <= `SEL_RESET;
            rdata_q <= {16'h0000, `SEL_RESET};
        end
        else
        begin
            state_q <= state_d;
            uart_q <= uart_d;
            spi_cd_q <= spi_cd_d;
            spi_ss_q <= spi_ss_d;
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            flt56_q <= flt56_d;
            flt78_q <= flt78_d;
            out3233_q <= out3233_d;
            out3435_q <= out3435_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && (state_q != ANSWER);
    assign avs_readdata = rdata_q;

    // choices in peripheral order, matching the struct fields
    pin_choice_type choices [11];
    logic [10:0] routed;

    always_comb
    begin
        choices[0] = uart_q[`LOW_LSB +: 8];
        choices[1] = uart_q[`HIGH_LSB +: 8];
        choices[2] = spi_cd_q[`HIGH_LSB +: 8];
        choices[3] = spi_cd_q[`LOW_LSB +: 8];
        choices[4] = spi_ss_q[`LOW_LSB +: 8];
        choices[5] = sync1_q[`HIGH_LSB +: 8];
        choices[6] = sync2_q[`LOW_LSB +: 8];
        choices[7] = flt56_q[`LOW_LSB +: 8];
        choices[8] = flt56_q[`HIGH_LSB +: 8];
        choices[9] = flt78_q[`LOW_LSB +: 8];
        choices[10] = flt78_q[`HIGH_LSB +: 8];
    end

    for (genvar g = 0; g < 11; g++)
    begin : g_route
        pin_input_route #(.NUM_PINS(NUM_PINS)) u_route (
            .pins(pins_vec),
            .choice(choices[g]),
            .routed(routed[g])
        );
    end

    // struct's first field is the msb, so reverse the vector
    always_comb
    begin
        periph_in.uart_receive_input = routed[0];
        periph_in.uart_clear_to_send_input = routed[1];
        periph_in.spi_clock_in = routed[2];
        periph_in.spi_data_in = routed[3];
        periph_in.spi_slave_select_input = routed[4];
        periph_in.pwm_sync_one_in = routed[5];
        periph_in.pwm_sync_two_in = routed[6];
        periph_in.fault_five_in = routed[7];
        periph_in.fault_six_in = routed[8];
        periph_in.fault_seven_in = routed[9];
        periph_in.fault_eight_in = routed[10];
    end

    always_comb
    begin
        out_sel.pin32_output_function = out3233_q[5:0];
        out_sel.pin33_output_function = out3233_q[13:8];
        out_sel.pin34_output_function = out3435_q[5:0];
        out_sel.pin35_output_function = out3435_q[13:8];
    end

    a_zero_gives_low: assert property (@(posedge clk) disable iff (!arst_n)
        (uart_q[7:0] == 8'h00) |-> !periph_in.uart_receive_input)
        else $error("zero choice did not give low");

    a_route_pin_n: assert property (@(posedge clk) disable iff (!arst_n)
        (spi_ss_q[7:0] != 8'h00 && int'(spi_ss_q[7:0]) <= NUM_PINS)
        |-> periph_in.spi_slave_select_input == pins_vec[spi_ss_q[7:0]])
        else $error("slave select not routed from chosen pin");

    a_unimpl_read_zero: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == ANSWER && avs_read && avs_address == `OFS_OUT3435_SEL)
        |-> (avs_readdata & 32'hFFFF_C0C0) == 32'h0000_0000)
        else $error("unimplemented output bits read nonzero");

    a_write_readback: assert property (@(posedge clk) disable iff (!arst_n)
        (do_write && avs_address == `OFS_UART_SEL && avs_byteenable[1:0] == 2'b11)
        |=> uart_q == $past(avs_writedata[15:0]))
        else $error("uart select write lost");

    a_ss_high_zero: assert property (@(posedge clk) disable iff (!arst_n)
        spi_ss_q[15:8] == 8'h00)
        else $error("slave select upper byte stored");

    a_sync_bytes: assert property (@(posedge clk) disable iff (!arst_n)
        sync1_q[7:0] == 8'h00 && sync2_q[15:8] == 8'h00)
        else $error("sync unimplemented byte stored");

    a_cts_from_high: assert property (@(posedge clk) disable iff (!arst_n)
        (uart_q[15:8] == 8'h00) |-> !periph_in.uart_clear_to_send_input)
        else $error("clear to send not from high byte");

    a_out_field: assert property (@(posedge clk) disable iff (!arst_n)
        (do_write && avs_address == `OFS_OUT3233_SEL && avs_byteenable[1])
        |=> out_sel.pin33_output_function == $past(avs_writedata[13:8]))
        else $error("pin33 function not from bits 13-8");

    a_fault_six_high: assert property (@(posedge clk) disable iff (!arst_n)
        (flt56_q[15:8] == 8'h00) |-> !periph_in.fault_six_in)
        else $error("fault six not from high byte");
endmodule

/* File: verif/pin_level_model.sv */
// Purpose: stands in for the package pins feeding the remappable inputs
// Assumes: the bench picks one pin and the level it carries
// Notes: every other pin carries the inverse level, so a wrong route shows up
module pin_level_model
#(
    parameter int NUM_PINS = 181
)
(
    input wire logic clk,
    input wire logic [7:0] pick,
    input wire logic level,
    output logic [NUM_PINS:1] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // pins move just after the edge, like a real pad seen through the synchroniser;
    // they stay unknown until the first edge, which reset hides behind the synchroniser
    always @(posedge clk)
    begin
        for (int i = 1; i <= NUM_PINS; i++)
        begin
            pins[i] <= (i == int'(pick)) ? level : !level;
        end
    end
endmodule

/* File: verif/remappable_pin_select_tb_top.sv */
// Purpose: self-checking bench for the remappable pin select unit
// Assumes: one wait cycle per access; pins reach periph_in two edges later
// Notes: register masks and field places are written out here, not taken from the design
module remappable_pin_select_tb_top
    import pin_select_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [3:0] lanes = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [181:1] pins;
    logic [7:0] pick = 8'h00;
    logic level = 1'b0;
    periph_in_type periph_in;
    out_sel_type out_sel;
    int bad_count = 0;
    int total_checks = 0;
    logic [7:0] reg_ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    logic [15:0] reg_mask [9] = '{16'hFFFF, 16'hFFFF, 16'h00FF, 16'hFF00, 16'h00FF, 16'hFFFF, 16'hFFFF,
        16'h3F3F, 16'h3F3F};
    // one entry per periph_in field, msb first; fld_hi marks the upper byte
    logic [7:0] fld_ofs [11] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h14, 8'h18, 8'h18};
    logic [10:0] fld_hi = 11'h526;

    always #5 clk = ~clk;

    remappable_pin_select #(.NUM_PINS(181)) u_remappable_pin_select (
        .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .remappable_pin(pins), .periph_in(periph_in), .out_sel(out_sel));

    pin_level_model #(.NUM_PINS(181)) u_pin_level_model (
        .clk(clk), .pick(pick), .level(level), .pins(pins));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        total_checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge, released on that same edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= lanes;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0)
        begin
            bad_count++;
            give_verdict();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic reset_values();
        logic [31:0] q;
        for (int i = 0; i < 9; i++)
        begin
            bus(1'b0, reg_ofs[i], 16'h0000, q);
            check(q, 32'h0000_0000, "reset value");
        end
        check({8'h00, out_sel}, 32'h0000_0000, "out_sel after reset");
        // the pin model drives every pin high here, so any live route would show
        check({21'h000000, periph_in}, 32'h0000_0000, "periph_in after reset");
        $display("test reset_values done");
    endtask

    task automatic readback();
        logic [31:0] q;
        for (int i = 0; i < 9; i++)
        begin
            bus(1'b1, reg_ofs[i], 16'hFFFF, q);
            bus(1'b0, reg_ofs[i], 16'h0000, q);
            check(q, {16'h0000, reg_mask[i]}, "read back");
        end
        bus(1'b1, 8'h24, 16'hFFFF, q);
        bus(1'b0, 8'h24, 16'h0000, q);
        check(q, 32'h0000_0000, "unmapped read");
        $display("test readback done");
    endtask

    task automatic out_select();
        logic [31:0] q;
        bus(1'b1, 8'h1C, 16'hEAD5, q);
        bus(1'b1, 8'h20, 16'h3F01, q);
        bus(1'b0, 8'h1C, 16'h0000, q);
        check(q, 32'h0000_2A15, "output pair read");
        check({8'h00, out_sel}, {8'h00, 6'h3F, 6'h01, 6'h2A, 6'h15}, "out_sel fields");
        $display("test out_select done");
    endtask

    // each byte lane writes only its own byte of the register
    task automatic byte_lanes();
        logic [31:0] q;
        bus(1'b1, 8'h00, 16'h0000, q);
        lanes = 4'h1;
        bus(1'b1, 8'h00, 16'hABCD, q);
        lanes = 4'hF;
        bus(1'b0, 8'h00, 16'h0000, q);
        check(q, 32'h0000_00CD, "low lane write");
        lanes = 4'h2;
        bus(1'b1, 8'h00, 16'h1234, q);
        lanes = 4'hF;
        bus(1'b0, 8'h00, 16'h0000, q);
        check(q, 32'h0000_12CD, "high lane write");
        bus(1'b1, 8'h00, 16'h0000, q);
        $display("test byte_lanes done");
    endtask

    task automatic settle_and_check(input logic [10:0] want, input string what);
        repeat (4) @(posedge clk);
        @(negedge clk);
        check({21'h000000, periph_in}, {21'h000000, want}, what);
    endtask

    // pin numbers step up to 181 so the top code is exercised; idle fields must stay low
    task automatic routing();
        logic [31:0] q;
        logic [7:0] n;
        for (int k = 0; k < 11; k++)
        begin
            n = 8'(1 + k * 18);
            bus(1'b1, fld_ofs[k], fld_hi[k] ? {n, 8'h00} : {8'h00, n}, q);
            pick <= n;
            level <= 1'b1;
            settle_and_check(11'h400 >> k, "routed high");
            level <= 1'b0;
            settle_and_check(11'h000, "routed low, others tied low");
            bus(1'b1, fld_ofs[k], 16'h0000, q);
        end
        $display("test routing done");
    endtask

    initial
    begin
        logic [31:0] scratch;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        reset_values();
        readback();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        reset_values();
        out_select();
        byte_lanes();
        bus(1'b1, 8'h1C, 16'h0000, scratch);
        bus(1'b1, 8'h20, 16'h0000, scratch);
        routing();
        give_verdict();
    end
endmodule
